// file: core/rcw_reset_cause_watchdog.sv
// Reset sequencer with cause flags, debug force-reset, write-once options and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "rcw_defs.svh"
module rcw_reset_cause_watchdog import rcw_pkg::*; #(
  parameter int LPO_DIV = `RCW_LPO_CYC,
  parameter int HOLD_CYC = `RCW_HOLD_CYC
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic reset_n,
  // Register access from processor or debug host
  input wire rcw_reg_req_type regReq,
  output logic [7:0] rdData_ff,
  output logic rdValid_ff,
  // Reset source pins
  input wire rcw_pins_type pinsIn,
  // Processor events and mode enables
  input wire rcw_cpu_evt_type cpuEvt,
  input wire logic backgroundModeEnable,
  input wire logic lowVoltResetEnable,
  input wire logic lowVoltStopEnable,
  // System control
  output logic sysReset,
  output logic stopGrant_ff
);
  logic [1:0] rstPipe_ff;
  logic rstSync_n;
  rcw_pins_type pinA_ff;
  rcw_pins_type pinB_ff;
  rcw_pins_type pinC_ff;
  rcw_pins_type pinState_ff;
  rcw_pins_type nxt_pinState;
  rcw_state_type state_ff;
  rcw_state_type nxt_state;
  logic [3:0] holdCnt_ff;
  logic [7:0] cause_ff;
  logic [7:0] nxt_cause;
  logic [7:0] opts_ff;
  logic optsDone_ff;
  logic [7:0] wdgOpt_ff;
  logic wdgOptDone_ff;
  rcw_wdg_cfg_type wdgCfg;
  logic running;
  logic regWrite;
  logic dbgForce;
  logic causeWrite;
  logic illegal;
  logic pinReset;
  logic lvReset;
  logic clockLost;
  logic wdgExpire;
  logic windowOpen;
  logic windowViol;
  logic wdgTrip;
  logic resetEvent;
  logic levelActive;

  // Release of the power-on reset is retimed; assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_ff[1];

  // Pin inputs: three flops, a change counts once the last two agree
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinA_ff <= `RCW_PIN_IDLE;
      pinB_ff <= `RCW_PIN_IDLE;
      pinC_ff <= `RCW_PIN_IDLE;
      pinState_ff <= `RCW_PIN_IDLE;
    end else begin
      pinA_ff <= pinsIn;
      pinB_ff <= pinA_ff;
      pinC_ff <= pinB_ff;
      pinState_ff <= nxt_pinState;
    end
  end
  assign nxt_pinState = ((pinB_ff ~^ pinC_ff) & pinC_ff) | ((pinB_ff ^ pinC_ff) & pinState_ff);

  // Reset sources
  assign running = (state_ff == RCW_RUN);
  assign regWrite = running && regReq.write;
  assign pinReset = !pinState_ff.extReset_n;
  assign clockLost = pinState_ff.clockLost;
  // Low-voltage trip only resets when both enables are set
  assign lvReset = pinState_ff.lowVoltTrip && lowVoltResetEnable && lowVoltStopEnable;
  // Only background debug writes can force a reset; user writes are dropped
  assign dbgForce = regWrite && regReq.debug && regReq.index == `RCW_IDX_DBGRST
    && regReq.wdata[`RCW_BIT_DBGRST];
  assign causeWrite = regWrite && regReq.index == `RCW_IDX_CAUSE;
  assign illegal = running && (cpuEvt.unimplOpcode
    || (cpuEvt.stopExec && !opts_ff[`RCW_OPT_STOP])
    || (cpuEvt.bgndExec && !backgroundModeEnable));
  // An early restart write in window mode is itself a watchdog reset
  assign windowViol = causeWrite && wdgCfg.window && wdgCfg.busSource
    && wdgCfg.timeout != 2'h0 && !windowOpen;
  assign wdgTrip = wdgExpire || windowViol;
  assign resetEvent = running && (pinReset || clockLost || lvReset || illegal || wdgTrip || dbgForce);
  // Level sources keep the device in reset until they go away
  assign levelActive = pinReset || clockLost || lvReset;

  // Flags of every source active at the reset moment, POR kept through a low-voltage reset; all cleared on a debug force
  always_comb begin
    nxt_cause = 8'h00;
    nxt_cause[`RCW_BIT_POR] = lvReset && cause_ff[`RCW_BIT_POR];
    nxt_cause[`RCW_BIT_PIN] = pinReset;
    nxt_cause[`RCW_BIT_WDG] = wdgTrip;
    nxt_cause[`RCW_BIT_ILL] = illegal;
    nxt_cause[`RCW_BIT_LOC] = clockLost;
    nxt_cause[`RCW_BIT_LVD] = lvReset;
    if (dbgForce) begin
      nxt_cause = 8'h00;
    end
  end

  // Cause flags: power-on value, else captured at each reset event
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cause_ff <= `RCW_CAUSE_POR_VAL;
    end else if (resetEvent) begin
      cause_ff <= nxt_cause;
    end
  end

  // Sequencer: hold the system in reset for a fixed time and while levels persist
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RCW_RUN: begin
        if (resetEvent) begin
          nxt_state = RCW_HOLD;
        end
      end
      RCW_HOLD: begin
        if (holdCnt_ff == 4'h0 && !levelActive) begin
          nxt_state = RCW_RUN;
        end
      end
      default: nxt_state = RCW_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_ff <= RCW_HOLD;
      holdCnt_ff <= 4'(HOLD_CYC - 1);
    end else begin
      state_ff <= nxt_state;
      if (running) begin
        holdCnt_ff <= 4'(HOLD_CYC - 1);
      end else if (holdCnt_ff != 4'h0) begin
        holdCnt_ff <= holdCnt_ff - 4'h1;
      end
    end
  end
  assign sysReset = (state_ff == RCW_HOLD);

  // Options register: write-once until the next reset of any kind
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      opts_ff <= `RCW_OPT_RST_VAL;
      optsDone_ff <= 1'b0;
    end else if (sysReset) begin
      opts_ff <= `RCW_OPT_RST_VAL;
      optsDone_ff <= 1'b0;
    end else if (regWrite && regReq.index == `RCW_IDX_OPTS && !optsDone_ff) begin
      opts_ff <= regReq.wdata & `RCW_OPT_IMPL_MASK;
      optsDone_ff <= 1'b1;
    end
  end

  // Watchdog source and window bits: same write-once discipline
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wdgOpt_ff <= `RCW_WDGOPT_RST_VAL;
      wdgOptDone_ff <= 1'b0;
    end else if (sysReset) begin
      wdgOpt_ff <= `RCW_WDGOPT_RST_VAL;
      wdgOptDone_ff <= 1'b0;
    end else if (regWrite && regReq.index == `RCW_IDX_WDGOPT && !wdgOptDone_ff) begin
      wdgOpt_ff <= regReq.wdata & `RCW_WDGOPT_MASK;
      wdgOptDone_ff <= 1'b1;
    end
  end

  assign wdgCfg.timeout = opts_ff[7:6];
  assign wdgCfg.busSource = wdgOpt_ff[7];
  assign wdgCfg.window = wdgOpt_ff[6];

  // Held in restart during reset so the count begins at zero afterwards
  rcw_watchdog #(
    .LPO_DIV(LPO_DIV)
  ) wdg (
    .clk(clk),
    .rst_n(rstSync_n),
    .restart(sysReset || causeWrite),
    .cfg(wdgCfg),
    .expire_ff(wdgExpire),
    .windowOpen(windowOpen)
  );

  // Read data answers one cycle after the request
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rdData_ff <= 8'h00;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= regReq.read;
      case (regReq.index)
        `RCW_IDX_CAUSE: rdData_ff <= cause_ff;
        `RCW_IDX_DBGRST: rdData_ff <= 8'h00;
        `RCW_IDX_OPTS: rdData_ff <= opts_ff & `RCW_OPT_IMPL_MASK;
        default: rdData_ff <= wdgOpt_ff;
      endcase
    end
  end

  // Stop is granted only while enabled; otherwise it became an illegal reset
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stopGrant_ff <= 1'b0;
    end else begin
      stopGrant_ff <= running && cpuEvt.stopExec && opts_ff[`RCW_OPT_STOP];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync_n);

  dbg_clears_a: assert property (dbgForce |=> cause_ff == 8'h00)
    else $error("debug reset left a flag set");
  user_dbg_ignored_a: assert property (regWrite && !regReq.debug |-> !dbgForce)
    else $error("user write forced a reset");
  cause_kept_a: assert property (causeWrite && !resetEvent |=> $stable(cause_ff))
    else $error("restart write changed the flags");
  lvr_keeps_por_a: assert property (resetEvent && lvReset && !dbgForce
    |=> cause_ff[`RCW_BIT_LVD] && cause_ff[`RCW_BIT_POR] == $past(cause_ff[`RCW_BIT_POR]))
    else $error("low-voltage reset flags wrong");
  opts_once_a: assert property (optsDone_ff && !sysReset |=> $stable(opts_ff))
    else $error("options register took a second write");
  opts_rsvd_a: assert property (rdValid_ff && $past(regReq.index) == `RCW_IDX_OPTS
    |-> rdData_ff[3:2] == 2'h0) else $error("options bits 3:2 not zero");
  dbg_read_zero_a: assert property (regReq.read && regReq.index == `RCW_IDX_DBGRST
    |=> rdData_ff == 8'h00) else $error("force-reset register read nonzero");
  hold_len_a: assert property (resetEvent |=> sysReset[*8])
    else $error("reset hold too short");
  stop_ill_a: assert property (running && cpuEvt.stopExec && !opts_ff[`RCW_OPT_STOP] && !dbgForce
    |=> cause_ff[`RCW_BIT_ILL] && sysReset) else $error("disabled stop did not reset");
  window_viol_a: assert property (windowViol && !dbgForce
    |=> sysReset && cause_ff[`RCW_BIT_WDG]) else $error("early restart did not reset");
  wdg_flag_a: assert property (running && wdgExpire && !dbgForce |=> cause_ff[`RCW_BIT_WDG])
    else $error("watchdog expiry flag missing");

  dbg_reset_c: cover property (dbgForce ##1 sysReset);
  wdg_reset_c: cover property (running && wdgExpire);
  window_viol_c: cover property (windowViol);
  opts_second_c: cover property (optsDone_ff && regWrite && regReq.index == `RCW_IDX_OPTS);
endmodule : rcw_reset_cause_watchdog
`default_nettype wire

// file: core/rcw_defs.svh
// Constants for the reset cause, debug force-reset and options block
`ifndef RCW_DEFS_SVH
`define RCW_DEFS_SVH
`define RCW_IDX_CAUSE 2'h0
`define RCW_IDX_DBGRST 2'h1
`define RCW_IDX_OPTS 2'h2
`define RCW_IDX_WDGOPT 2'h3
`define RCW_BIT_POR 7
`define RCW_BIT_PIN 6
`define RCW_BIT_WDG 5
`define RCW_BIT_ILL 4
`define RCW_BIT_LOC 2
`define RCW_BIT_LVD 1
`define RCW_CAUSE_POR_VAL 8'h82
`define RCW_BIT_DBGRST 0
`define RCW_OPT_STOP 5
`define RCW_OPT_IMPL_MASK 8'hF3
`define RCW_OPT_RST_VAL 8'hC0
`define RCW_WDGOPT_MASK 8'hC0
`define RCW_WDGOPT_RST_VAL 8'h00
`define RCW_PIN_IDLE 3'h4
`define RCW_EXP_LPO1 5'h05
`define RCW_EXP_LPO2 5'h08
`define RCW_EXP_LPO3 5'h0A
`define RCW_EXP_BUS1 5'h0D
`define RCW_EXP_BUS2 5'h10
`define RCW_EXP_BUS3 5'h12
`define RCW_WIN_BUS1 19'h01800
`define RCW_WIN_BUS2 19'h0C000
`define RCW_WIN_BUS3 19'h30000
`define RCW_CLK_NS 20
`define RCW_HOLD_NS 200
`define RCW_HOLD_CYC ((`RCW_HOLD_NS + `RCW_CLK_NS - 1) / `RCW_CLK_NS)
`define RCW_LPO_NS 1000000
`define RCW_LPO_CYC (`RCW_LPO_NS / `RCW_CLK_NS)
`endif

// file: core/rcw_pkg.sv
// Types shared by the reset cause, watchdog and options logic
package rcw_pkg;
  typedef struct packed {
    logic write;
    logic read;
    logic debug;
    logic [1:0] index;
    logic [7:0] wdata;
  } rcw_reg_req_type;
  typedef struct packed {
    logic extReset_n;
    logic lowVoltTrip;
    logic clockLost;
  } rcw_pins_type;
  typedef struct packed {
    logic unimplOpcode;
    logic stopExec;
    logic bgndExec;
  } rcw_cpu_evt_type;
  typedef struct packed {
    logic [1:0] timeout;
    logic busSource;
    logic window;
  } rcw_wdg_cfg_type;
  typedef enum logic [1:0] {RCW_RUN = 2'b01, RCW_HOLD = 2'b10} rcw_state_type;
endpackage : rcw_pkg

// file: core/rcw_watchdog.sv
// Watchdog counter with low-power tick divider and window decode
`timescale 1ns/1ps
`default_nettype none
`include "rcw_defs.svh"
module rcw_watchdog import rcw_pkg::*; #(
  parameter int LPO_DIV = `RCW_LPO_CYC
) (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire rcw_wdg_cfg_type cfg,
  // Status
  output logic expire_ff,
  output logic windowOpen
);
  localparam int DW = $clog2(LPO_DIV);
  logic [DW-1:0] divCnt_ff;
  logic [18:0] count_ff;
  logic tick;
  logic enabled;

  function automatic logic [18:0] wdgLimit(input rcw_wdg_cfg_type c);
    logic [4:0] e;
    e = 5'h00;
    case (c.timeout)
      2'h1: e = c.busSource ? `RCW_EXP_BUS1 : `RCW_EXP_LPO1;
      2'h2: e = c.busSource ? `RCW_EXP_BUS2 : `RCW_EXP_LPO2;
      default: e = c.busSource ? `RCW_EXP_BUS3 : `RCW_EXP_LPO3;
    endcase
    wdgLimit = 19'h00001 << e;
  endfunction : wdgLimit

  function automatic logic [18:0] wdgWindow(input rcw_wdg_cfg_type c);
    case (c.timeout)
      2'h1: wdgWindow = `RCW_WIN_BUS1;
      2'h2: wdgWindow = `RCW_WIN_BUS2;
      default: wdgWindow = `RCW_WIN_BUS3;
    endcase
  endfunction : wdgWindow

  assign enabled = (cfg.timeout != 2'h0);
  // Low-power source is a divided tick of the bus clock
  assign tick = enabled && (cfg.busSource || (divCnt_ff == DW'(LPO_DIV - 1)));
  // Window timing only exists on the bus clock source
  assign windowOpen = !(cfg.window && cfg.busSource) || (count_ff >= wdgWindow(cfg));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_ff <= '0;
    end else if (restart || divCnt_ff == DW'(LPO_DIV - 1)) begin
      divCnt_ff <= '0;
    end else begin
      divCnt_ff <= divCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 19'h00000;
      expire_ff <= 1'b0;
    end else if (restart) begin
      count_ff <= 19'h00000;
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= tick && (count_ff == wdgLimit(cfg) - 19'h00001);
      if (!enabled || (tick && count_ff == wdgLimit(cfg) - 19'h00001)) begin
        count_ff <= 19'h00000;
      end else if (tick) begin
        count_ff <= count_ff + 19'h00001;
      end
    end
  end

  wdg_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.timeout == 2'h0) |=> !expire_ff) else $error("watchdog fired while disabled");
  wdg_bus_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.busSource && cfg.timeout == 2'h1 && !restart && count_ff == 19'h01FFF) |=> expire_ff)
    else $error("bus clock short timeout not at 2^13");
  wdg_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    restart |=> (count_ff == 19'h00000) && !expire_ff) else $error("restart did not zero count");
endmodule : rcw_watchdog
`default_nettype wire

// file: verification/rcw_host_model.sv
// Far-side model: processor software, debug host and reset-source pins
`timescale 1ns/1ps
`default_nettype none
module rcw_host_model import rcw_pkg::*; (
  // Clock
  input wire logic clk,
  // Toward the block
  output var rcw_reg_req_type regReq,
  output var rcw_pins_type pinsIn,
  output var rcw_cpu_evt_type cpuEvt,
  output logic backgroundModeEnable,
  output logic lowVoltResetEnable,
  output logic lowVoltStopEnable
);
  initial begin
    regReq = '0;
    pinsIn = 3'b100;
    cpuEvt = '0;
    backgroundModeEnable = 1'b0;
    lowVoltResetEnable = 1'b0;
    lowVoltStopEnable = 1'b0;
  end
  // Released data lines show the inverse, so a stale value is never trusted
  task automatic wr(input logic [1:0] idx, input logic [7:0] data, input logic dbg);
    @(posedge clk);
    regReq <= '{write: 1'b1, read: 1'b0, debug: dbg, index: idx, wdata: data};
    @(posedge clk);
    regReq.write <= 1'b0;
    regReq.wdata <= ~data;
  endtask : wr
  task automatic rd(input logic [1:0] idx);
    @(posedge clk);
    regReq <= '{write: 1'b0, read: 1'b1, debug: 1'b0, index: idx, wdata: 8'h00};
    @(posedge clk);
    regReq.read <= 1'b0;
  endtask : rd
  // Start-up code writes both write-once registers after a reset
  task automatic boot(input logic [7:0] opt, input logic [7:0] wopt);
    wr(2'h2, opt, 1'b0);
    wr(2'h3, wopt, 1'b0);
  endtask : boot
  task automatic pins(input rcw_pins_type p);
    @(posedge clk);
    pinsIn <= p;
  endtask : pins
  task automatic modes(input logic bg, input logic re, input logic se);
    @(posedge clk);
    backgroundModeEnable <= bg;
    lowVoltResetEnable <= re;
    lowVoltStopEnable <= se;
  endtask : modes
  task automatic evt(input rcw_cpu_evt_type e);
    @(posedge clk);
    cpuEvt <= e;
    @(posedge clk);
    cpuEvt <= '0;
  endtask : evt
endmodule : rcw_host_model
`default_nettype wire

// file: verification/tb.sv
// Testbench for the reset cause, debug force-reset and options block
`timescale 1ns/1ps
`default_nettype none
module tb import rcw_pkg::*; ();
  localparam rcw_pins_type PIDLE = 3'b100;
  localparam rcw_pins_type PSRC [4] = '{3'b110, 3'b000, 3'b101, 3'b110};
  localparam logic [7:0] PEXP [4] = '{8'h82, 8'h40, 8'h04, 8'h02};
  localparam rcw_cpu_evt_type EVT [3] = '{3'b100, 3'b010, 3'b001};
  logic clk;
  logic reset_n;
  rcw_reg_req_type regReq;
  rcw_pins_type pinsIn;
  rcw_cpu_evt_type cpuEvt;
  logic bgEn;
  logic lvRe;
  logic lvSe;
  logic [7:0] rdData_ff;
  logic rdValid_ff;
  logic sysReset;
  logic stopGrant_ff;
  int n_errors;
  int checked;
  // Short low-power divider keeps the oscillator timeouts affordable
  rcw_reset_cause_watchdog #(.LPO_DIV(4), .HOLD_CYC(10)) uut (.clk(clk), .reset_n(reset_n), .regReq(regReq),
    .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff), .pinsIn(pinsIn), .cpuEvt(cpuEvt),
    .backgroundModeEnable(bgEn), .lowVoltResetEnable(lvRe), .lowVoltStopEnable(lvSe),
    .sysReset(sysReset), .stopGrant_ff(stopGrant_ff));
  rcw_host_model host (.clk(clk), .regReq(regReq), .pinsIn(pinsIn), .cpuEvt(cpuEvt),
    .backgroundModeEnable(bgEn), .lowVoltResetEnable(lvRe), .lowVoltStopEnable(lvSe));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rdchk(input logic [1:0] idx, input logic [7:0] exp, input string what);
    host.rd(idx);
    #1;
    check("rd valid", {7'h00, rdValid_ff}, 8'h01);
    check(what, rdData_ff, exp);
  endtask : rdchk
  task automatic wait_rst(input logic lvl, input int lim, input string what);
    for (int i = 0; i < lim && sysReset !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    if (sysReset !== lvl) begin
      check(what, {7'h00, sysReset}, {7'h00, lvl});
      end_sim();
    end
  endtask : wait_rst
  task automatic quiet(input int n, input string what);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      if (sysReset !== 1'b0) hit = 1'b1;
    end
    check(what, {7'h00, hit}, 8'h00);
  endtask : quiet
  task automatic expect_cause(input int lim, input logic [7:0] exp, input string what);
    wait_rst(1'b1, lim, what);
    wait_rst(1'b0, 100, what);
    rdchk(2'h0, exp, what);
  endtask : expect_cause
  task automatic src_reset(input rcw_pins_type p, input logic [7:0] exp);
    host.pins(p);
    wait_rst(1'b1, 10, "src on");
    host.pins(PIDLE);
    wait_rst(1'b0, 100, "src off");
    rdchk(2'h0, exp, "src cause");
  endtask : src_reset
  initial begin
    reset_n = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    wait_rst(1'b0, 100, "por");
    rdchk(2'h0, 8'h82, "cause");
    rdchk(2'h1, 8'h00, "dbg reg");
    rdchk(2'h2, 8'hC0, "opts");
    host.modes(1'b0, 1'b1, 1'b1);
    for (int k = 0; k < 4; k++) src_reset(PSRC[k], PEXP[k]);
    host.modes(1'b0, 1'b1, 1'b0);
    host.pins(PSRC[0]);
    quiet(20, "lv one enable");
    host.pins(PIDLE);
    host.boot(8'h00, 8'h80);
    host.wr(2'h2, 8'hFF, 1'b0);
    host.wr(2'h3, 8'h40, 1'b0);
    rdchk(2'h2, 8'h00, "opts once");
    rdchk(2'h3, 8'h80, "wdg once");
    host.wr(2'h0, 8'hFF, 1'b0);
    rdchk(2'h0, 8'h02, "cause kept");
    host.wr(2'h1, 8'h01, 1'b0);
    host.wr(2'h1, 8'hFE, 1'b1);
    quiet(9000, "wdg off");
    for (int k = 0; k < 3; k++) begin
      host.evt(EVT[k]);
      expect_cause(5, 8'h10, "illegal");
    end
    rdchk(2'h2, 8'hC0, "opts reload");
    host.modes(1'b1, 1'b1, 1'b1);
    host.boot(8'h20, 8'h00);
    host.evt(EVT[1]);
    #1;
    check("stop grant", {7'h00, stopGrant_ff}, 8'h01);
    host.evt(EVT[2]);
    quiet(20, "background_entry_instruction ok");
    host.wr(2'h1, 8'h01, 1'b1);
    expect_cause(5, 8'h00, "debug force");
    host.boot(8'h40, 8'h80);
    quiet(5000, "wdg bus");
    host.wr(2'h0, 8'h00, 1'b0);
    quiet(8000, "restart");
    expect_cause(400, 8'h20, "bus exp");
    host.boot(8'h40, 8'h00);
    quiet(100, "lpo1");
    expect_cause(100, 8'h20, "lpo1 exp");
    host.boot(8'h80, 8'h00);
    quiet(950, "lpo2");
    expect_cause(150, 8'h20, "lpo2 exp");
    host.boot(8'hC0, 8'h00);
    quiet(3900, "lpo3");
    expect_cause(400, 8'h20, "lpo3 exp");
    host.boot(8'h40, 8'hC0);
    host.wr(2'h0, 8'h00, 1'b0);
    expect_cause(5, 8'h20, "early");
    host.boot(8'h40, 8'hC0);
    quiet(6200, "win");
    // Restart only inside the last quarter of the period
    host.wr(2'h0, 8'h00, 1'b0);
    quiet(6200, "win restart");
    expect_cause(2100, 8'h20, "win exp");
    end_sim();
  end
endmodule : tb
`default_nettype wire
